// [epc_pkg.sv]
package epc_pkg;
  // register addresses on the five-bit address lines
  localparam logic [4:0] ADDR_VECTOR   = 5'h12;
  localparam logic [4:0] ADDR_BER      = 5'h18;
  localparam logic [4:0] ADDR_RAICRC   = 5'h19;
  localparam logic [4:0] ADDR_FAS      = 5'h1A;
  localparam logic [4:0] ADDR_BPV_HIGH = 5'h1C;
  localparam logic [4:0] ADDR_BPV_LOW  = 5'h1D;
  localparam logic [4:0] ADDR_EBIT     = 5'h1E;
  localparam logic [4:0] ADDR_CRC4     = 5'h1F;
  // widths and values
  localparam int         DATA_W        = 8;
  localparam int         ADDR_W        = 5;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [7:0] ONE_BYTE      = 8'h01;
  localparam logic [15:0] ONE_WORD     = 16'h0001;
endpackage : epc_pkg

// [epc_counter.sv]
`timescale 1ns/10ps
// one counter with host load; load wins over increment, wraps at the top
module epc_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             inc,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] value;
  } epc_cnt_state_t;

  epc_cnt_state_t state_q;
  epc_cnt_state_t state_d;

  // load or increment; no reset term, contents survive every reset
  always_comb begin
    state_d = state_q;
    if (load) begin
      state_d.value = load_value;
    end else if (inc) begin
      state_d.value = state_q.value + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // storage is not reset
  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  assign count = state_q.value;

  // storage powers up unknown, so the checks use exact match against the past value
  a_cnt_load : assert property (@(posedge clk) load |=> count === $past(load_value))
    else $error("counter did not take load value");
  a_cnt_incr : assert property (@(posedge clk) (inc && !load) |=>
    count === $past(count) + {{(WIDTH-1){1'b0}}, 1'b1})
    else $error("counter did not step or wrap");
  a_cnt_hold : assert property (@(posedge clk) (!inc && !load) |=>
    count === $past(count))
    else $error("counter changed without cause");
endmodule : epc_counter

// [epc_status_bank.sv]
`timescale 1ns/10ps
module epc_status_bank
  import epc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        cs_n,
  input  wire logic                        rw_n,
  input  wire logic                        ds_n,
  input  wire logic [epc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [epc_pkg::DATA_W-1:0]  data_in,
  output logic      [epc_pkg::DATA_W-1:0]  data_out,
  output logic                             data_oe,
  input  wire logic                        irq_event,
  input  wire logic [epc_pkg::DATA_W-1:0]  irq_vector,
  input  wire logic                        ber_select,
  input  wire logic                        bit_error_slot0,
  input  wire logic                        bit_error_slot1,
  input  wire logic                        multiframe_end,
  input  wire logic                        rx_rai_bit,
  input  wire logic                        rx_ebit1,
  input  wire logic                        rx_ebit2,
  input  wire logic                        fas_errored,
  input  wire logic                        bipolar_violation,
  input  wire logic                        ebit_error,
  input  wire logic                        crc4_error,
  input  wire logic                        datalink_due,
  output logic                             datalink_clock
);
  import epc_pkg::*;

  // bus and control state, reset to idle
  typedef struct packed {
    logic [7:0] vector;
    logic       rd_active;
    logic       rd_clear;
    logic       ds_prev;
    logic [7:0] rdata;
    logic       oe;
    logic       dl_clk;
  } epc_bank_state_t;

  epc_bank_state_t state_q;
  epc_bank_state_t state_d;

  logic        strobe_rise;
  logic        strobe_fall;
  logic        wr_take;
  logic [7:0]  ber_count;
  logic [7:0]  raicrc_count;
  logic [7:0]  fas_count;
  logic [15:0] bpv_count;
  logic [7:0]  ebit_count;
  logic [7:0]  crc4_count;
  logic        ld_ber;
  logic        ld_raicrc;
  logic        ld_fas;
  logic        ld_bpv;
  logic        ld_ebit;
  logic        ld_crc4;
  logic [15:0] bpv_load;
  logic        ber_inc;
  logic        raicrc_inc;

  // write target match on the five-bit address
  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = (a == target);
  endfunction : hit

  // strobe edges; ds_n low marks an access, taken when the strobe opens
  assign strobe_fall = state_q.ds_prev && !ds_n && !cs_n;
  assign strobe_rise = !state_q.ds_prev && ds_n;
  assign wr_take     = strobe_fall && !rw_n;

  // load strobes per counter
  assign ld_ber    = wr_take && hit(addr, ADDR_BER);
  assign ld_raicrc = wr_take && hit(addr, ADDR_RAICRC);
  assign ld_fas    = wr_take && hit(addr, ADDR_FAS);
  assign ld_ebit   = wr_take && hit(addr, ADDR_EBIT);
  assign ld_crc4   = wr_take && hit(addr, ADDR_CRC4);
  assign ld_bpv    = wr_take && (hit(addr, ADDR_BPV_HIGH) || hit(addr, ADDR_BPV_LOW));

  // byte write keeps the other half; low first then high avoids a carry mix
  assign bpv_load = hit(addr, ADDR_BPV_HIGH) ? {data_in, bpv_count[7:0]}
                                             : {bpv_count[15:8], data_in};

  // event qualification
  assign ber_inc    = ber_select ? bit_error_slot1 : bit_error_slot0;
  assign raicrc_inc = multiframe_end && rx_rai_bit && (!rx_ebit1 || !rx_ebit2);

  epc_counter #(.WIDTH(8)) u_ber (
    .clk        (clk),
    .inc        (ber_inc),
    .load       (ld_ber),
    .load_value (data_in),
    .count      (ber_count)
  );

  epc_counter #(.WIDTH(8)) u_raicrc (
    .clk        (clk),
    .inc        (raicrc_inc),
    .load       (ld_raicrc),
    .load_value (data_in),
    .count      (raicrc_count)
  );

  epc_counter #(.WIDTH(8)) u_fas (
    .clk        (clk),
    .inc        (fas_errored),
    .load       (ld_fas),
    .load_value (data_in),
    .count      (fas_count)
  );

  epc_counter #(.WIDTH(16)) u_bpv (
    .clk        (clk),
    .inc        (bipolar_violation),
    .load       (ld_bpv),
    .load_value (bpv_load),
    .count      (bpv_count)
  );

  epc_counter #(.WIDTH(8)) u_ebit (
    .clk        (clk),
    .inc        (ebit_error),
    .load       (ld_ebit),
    .load_value (data_in),
    .count      (ebit_count)
  );

  epc_counter #(.WIDTH(8)) u_crc4 (
    .clk        (clk),
    .inc        (crc4_error),
    .load       (ld_crc4),
    .load_value (data_in),
    .count      (crc4_count)
  );

  // read mux, unmapped addresses read zero
  function automatic logic [7:0] read_mux(input logic [4:0] a);
    unique case (a)
      ADDR_VECTOR:   read_mux = state_q.vector;
      ADDR_BER:      read_mux = ber_count;
      ADDR_RAICRC:   read_mux = raicrc_count;
      ADDR_FAS:      read_mux = fas_count;
      ADDR_BPV_HIGH: read_mux = bpv_count[15:8];
      ADDR_BPV_LOW:  read_mux = bpv_count[7:0];
      ADDR_EBIT:     read_mux = ebit_count;
      ADDR_CRC4:     read_mux = crc4_count;
      default:       read_mux = ZERO_BYTE;
    endcase
  endfunction : read_mux

  // next-state: bus read drive, vector capture and clear, link clock
  always_comb begin
    state_d          = state_q;
    state_d.ds_prev  = ds_n;
    state_d.dl_clk   = datalink_due;
    state_d.rd_clear = 1'b0;
    if (strobe_fall && rw_n) begin
      state_d.rd_active = 1'b1;
      state_d.rd_clear  = hit(addr, ADDR_VECTOR);
      state_d.rdata     = read_mux(addr);
      state_d.oe        = 1'b1;
    end else if (strobe_rise || cs_n) begin
      state_d.rd_active = 1'b0;
      state_d.oe        = 1'b0;
    end
    // clear when the vector read ends; a new event in that clock wins
    if (strobe_rise && state_q.rd_active && state_q.rd_clear) begin
      state_d.vector = ZERO_BYTE;
    end
    if (strobe_rise && !state_q.rd_clear) begin
      state_d.rd_clear = 1'b0;
    end else if (!strobe_rise && state_q.rd_clear) begin
      state_d.rd_clear = 1'b1;
    end
    if (irq_event) begin
      state_d.vector = irq_vector;
    end
  end

  // only control state is reset; counters sit in epc_counter unreset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
      state_q.ds_prev <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign data_out       = state_q.rdata;
  assign data_oe        = state_q.oe;
  assign datalink_clock = state_q.dl_clk;

  // vector capture and clear, counter steps, link clock, one read answer
  a_vec_clear : assert property (@(posedge clk) disable iff (reset)
    (strobe_rise && state_q.rd_active && state_q.rd_clear && !irq_event)
    |=> state_q.vector == ZERO_BYTE)
    else $error("vector not cleared after read");
  a_vec_capture : assert property (@(posedge clk) disable iff (reset)
    irq_event |=> state_q.vector == $past(irq_vector))
    else $error("vector not captured");
  a_ber_select : assert property (@(posedge clk) disable iff (reset)
    (!ld_ber && (ber_select ? bit_error_slot1 : bit_error_slot0))
    |=> ber_count == $past(ber_count) + ONE_BYTE)
    else $error("bit error count wrong slot");
  a_raicrc_cnt : assert property (@(posedge clk) disable iff (reset)
    (!ld_raicrc && !(multiframe_end && rx_rai_bit))
    |=> raicrc_count === $past(raicrc_count))
    else $error("alarm count moved without multiframe alarm");
  a_fas_cnt : assert property (@(posedge clk) disable iff (reset)
    (fas_errored && !ld_fas) |=> fas_count == $past(fas_count) + ONE_BYTE)
    else $error("fas count did not step");
  a_bpv_cnt : assert property (@(posedge clk) disable iff (reset)
    (bipolar_violation && !ld_bpv) |=> bpv_count == $past(bpv_count) + ONE_WORD)
    else $error("violation count did not step");
  a_bpv_low : assert property (@(posedge clk) disable iff (reset)
    (wr_take && addr == ADDR_BPV_LOW) |=> bpv_count[7:0] == $past(data_in))
    else $error("violation low byte not written");
  a_dl_pulse : assert property (@(posedge clk) disable iff (reset)
    datalink_due |=> datalink_clock)
    else $error("link clock not pulsed");
  a_read_data : assert property (@(posedge clk) disable iff (reset)
    (strobe_fall && rw_n && addr == ADDR_EBIT) |=> data_oe && data_out == $past(ebit_count))
    else $error("read data wrong");
  a_dl_idle : assert property (@(posedge clk) disable iff (reset)
    !datalink_due |=> !datalink_clock)
    else $error("link clock pulsed without cause");

  // bus side: drive stops with the strobe, answer stands while it is low
  a_oe_release : assert property (@(posedge clk) disable iff (reset)
    (strobe_rise || cs_n) |=> !data_oe)
    else $error("bus drive not released after strobe");
  a_rd_hold : assert property (@(posedge clk) disable iff (reset)
    (state_q.oe && !strobe_rise && !cs_n) |=> data_oe && $stable(data_out))
    else $error("read data changed during strobe");
  a_read_vec : assert property (@(posedge clk) disable iff (reset)
    (strobe_fall && rw_n && addr == ADDR_VECTOR) |=> data_out == $past(state_q.vector))
    else $error("vector read data wrong");
  a_vec_refuse : assert property (@(posedge clk) disable iff (reset)
    (wr_take && addr == ADDR_VECTOR && !irq_event) |=> $stable(state_q.vector))
    else $error("vector took a host write");

  // write path: every counter takes its preset byte
  a_ber_load : assert property (@(posedge clk) disable iff (reset)
    ld_ber |=> ber_count == $past(data_in))
    else $error("bit error count not preset");
  a_raicrc_load : assert property (@(posedge clk) disable iff (reset)
    ld_raicrc |=> raicrc_count == $past(data_in))
    else $error("alarm count not preset");
  a_fas_load : assert property (@(posedge clk) disable iff (reset)
    ld_fas |=> fas_count == $past(data_in))
    else $error("fas count not preset");
  a_ebit_load : assert property (@(posedge clk) disable iff (reset)
    ld_ebit |=> ebit_count == $past(data_in))
    else $error("e-bit count not preset");
  a_crc4_load : assert property (@(posedge clk) disable iff (reset)
    ld_crc4 |=> crc4_count == $past(data_in))
    else $error("crc-4 count not preset");
  a_bpv_high : assert property (@(posedge clk) disable iff (reset)
    (wr_take && addr == ADDR_BPV_HIGH)
    |=> bpv_count === {$past(data_in), $past(bpv_count[7:0])})
    else $error("violation high byte not written");

  // event paths: alarm multiframes, other slot, E-bit and CRC-4 errors
  a_raicrc_step : assert property (@(posedge clk) disable iff (reset)
    (multiframe_end && rx_rai_bit && !(rx_ebit1 && rx_ebit2) && !ld_raicrc)
    |=> raicrc_count == $past(raicrc_count) + ONE_BYTE)
    else $error("alarm count did not step");
  a_raicrc_both : assert property (@(posedge clk) disable iff (reset)
    (multiframe_end && rx_rai_bit && rx_ebit1 && rx_ebit2 && !ld_raicrc)
    |=> raicrc_count === $past(raicrc_count))
    else $error("alarm count stepped with both E-bits set");
  a_ber_other : assert property (@(posedge clk) disable iff (reset)
    (!ld_ber && !(ber_select ? bit_error_slot1 : bit_error_slot0))
    |=> ber_count === $past(ber_count))
    else $error("bit error count took the other slot");
  a_ebit_cnt : assert property (@(posedge clk) disable iff (reset)
    (ebit_error && !ld_ebit) |=> ebit_count == $past(ebit_count) + ONE_BYTE)
    else $error("e-bit count did not step");
  a_crc4_cnt : assert property (@(posedge clk) disable iff (reset)
    (crc4_error && !ld_crc4) |=> crc4_count == $past(crc4_count) + ONE_BYTE)
    else $error("crc-4 count did not step");
endmodule : epc_status_bank

// [epc_host.sv]
`timescale 1ns/10ps
// host model: parallel bus master, strobe length set per access, never waits
module epc_host
  import epc_pkg::*;
(
  input  wire logic                  clk,
  output logic                       cs_n,
  output logic                       rw_n,
  output logic                       ds_n,
  output logic [epc_pkg::ADDR_W-1:0] addr,
  output logic [epc_pkg::DATA_W-1:0] data_in
);
  // idle bus at time zero
  initial begin
    cs_n = 1'b1;
    rw_n = 1'b1;
    ds_n = 1'b1;
    addr = 5'h00;
    data_in = 8'h00;
  end
  // one access on five address lines and eight data lines, no acknowledge
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d, input int hold);
    @(posedge clk);
    cs_n    <= 1'b0;
    rw_n    <= rd;
    addr    <= a;
    data_in <= d;
    ds_n    <= 1'b0;
    repeat (hold) @(posedge clk);
    ds_n    <= 1'b1;
    cs_n    <= 1'b1;
    data_in <= ~d; // released bus must not keep the last value
    @(posedge clk);
  endtask : xfer
endmodule : epc_host

// [tb_epc_status_bank.sv]
`timescale 1ns/10ps
// self-checking bench for the status bank
module tb_epc_status_bank;
  import epc_pkg::*;
  localparam logic [4:0] CA [7] = '{ADDR_BER, ADDR_RAICRC, ADDR_FAS, ADDR_BPV_LOW,
                                    ADDR_BPV_HIGH, ADDR_EBIT, ADDR_CRC4};
  logic        clk, reset, data_oe, datalink_clock, oe_seen, cs_n, rw_n, ds_n;
  logic [4:0]  addr;
  logic [7:0]  data_in, data_out, vec;
  logic [7:0]  m [0:31];
  logic [7:0]  exp_q [$];
  logic [12:0] ev;
  int          fails, checked, i, n;

  epc_host host (.clk(clk), .cs_n(cs_n), .rw_n(rw_n), .ds_n(ds_n), .addr(addr),
                 .data_in(data_in));
  epc_status_bank dut (.clk(clk), .reset(reset), .cs_n(cs_n), .rw_n(rw_n), .ds_n(ds_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .irq_event(ev[0]), .irq_vector(vec), .ber_select(ev[1]), .bit_error_slot0(ev[2]),
    .bit_error_slot1(ev[3]), .multiframe_end(ev[4]), .rx_rai_bit(ev[5]), .rx_ebit1(ev[6]),
    .rx_ebit2(ev[7]), .fas_errored(ev[8]), .bipolar_violation(ev[9]), .ebit_error(ev[10]),
    .crc4_error(ev[11]), .datalink_due(ev[12]), .datalink_clock(datalink_clock));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // read: note the expected byte, vector clears behind the read
  task automatic rd(input logic [4:0] a);
    exp_q.push_back(m[a]);
    host.xfer(1'b1, a, 8'h00, 2 + $urandom_range(2));
    if (a == ADDR_VECTOR) m[a] = 8'h00;
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 2);
    m[a] = d;
  endtask : wr
  // k single-cycle pulses on one event input
  task automatic pulse(input int b, input int k);
    repeat (k) begin
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
    end
  endtask : pulse
  task automatic chk(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t data link clock", $time);
    end
  endtask : chk
  task automatic rd_all;
    for (int j = 0; j < 7; j++) rd(CA[j]);
  endtask : rd_all
  task results;
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // compare each read answer with the oldest note
  always @(negedge clk) begin
    if (data_oe === 1'b1 && oe_seen !== 1'b1) begin
      checked++;
      if (exp_q.size() == 0 || data_out !== exp_q[0]) begin
        fails++;
        $display("CHECK FAILED %0t read data %h", $time, data_out);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    oe_seen <= data_oe;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    ev = '0;
    vec = 8'h00;
    fails = 0;
    checked = 0;
    foreach (m[j]) m[j] = 8'h00;
    void'($urandom(31));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) wr(CA[i], 8'($urandom));
    rd_all();
    host.xfer(1'b0, ADDR_VECTOR, 8'hA5, 2);
    rd(ADDR_VECTOR);
    rd(5'h1B);
    wr(ADDR_FAS, 8'hFE);
    pulse(8, 3);
    m[ADDR_FAS] = 8'h01;
    wr(ADDR_BPV_LOW, 8'hFF);
    wr(ADDR_BPV_HIGH, 8'h12);
    pulse(9, 2);
    {m[ADDR_BPV_HIGH], m[ADDR_BPV_LOW]} = 16'h1301;
    for (i = 10; i < 12; i++) begin
      n = $urandom_range(1, 9);
      pulse(i, n);
      m[i == 10 ? ADDR_EBIT : ADDR_CRC4] += n[7:0];
    end
    for (i = 0; i < 2; i++) begin
      ev[1] <= i[0];
      n = $urandom_range(1, 6);
      pulse(2 + i, n);
      pulse(3 - i, 2);
      m[ADDR_BER] += n[7:0];
    end
    for (i = 0; i < 8; i++) begin
      ev[7:5] <= i[2:0];
      pulse(4, 1);
      if (i[0] && !(i[1] && i[2])) m[ADDR_RAICRC]++;
    end
    rd_all();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_all();
    vec <= 8'($urandom);
    pulse(0, 1);
    m[ADDR_VECTOR] = vec;
    rd(ADDR_VECTOR);
    rd(ADDR_VECTOR);
    pulse(12, 1);
    @(negedge clk);
    chk(datalink_clock === 1'b1);
    @(negedge clk);
    chk(datalink_clock === 1'b0);
    for (i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0) fails++;
    results();
  end
endmodule : tb_epc_status_bank
